// >>> param_add_sub_unit_test.sv
// Self-checking bench for the add/subtract unit.
`timescale 1ns/1ps
module param_add_sub_unit_test;
    localparam int W = 8; // The reference function below assumes this width.
    localparam int P = 2; // Two stages show both the shift and the clear tail.
    localparam logic [17:0] EDGE_W [4] = '{18'h3ffff, 18'h2017f, 18'h00180, 18'h10000};
    logic        clk = 1'b0, sys_rst = 1'b1, clear = 1'b1;
    logic [17:0] src_word = 18'h20000; // Select, carry, second and first operand.
    logic [W-1:0] operand_a, operand_b, result;
    logic        carry_in, add_sel, carry_out, overflow;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          fail_count = 0, total_checks = 0, cycles = 0;
    logic        m_ovr = 1'b0, m_op = 1'b0; // Model copy of the control register.
    bit          armed = 0;                 // Stages are unknown until the first clear.
    logic [9:0]  q[$];                      // Expected {overflow, carry, result} in flight.

    pasu_unit #(.PIPELINE(P)) dut (.*);
    pasu_src u_src (.word(src_word), .*);

    always #10 clk = ~clk;

    ////////////////////////////////////////
    // Sum or difference, with carry out and overflow, worked out in integers.
    function automatic logic [9:0] calc(input int a, input int b, input int ci, input int add);
        int bb;
        int s;
        int lo;
        bb = add ? b : (~b & 255);
        s  = a + bb + ci;
        lo = (a & 127) + (bb & 127) + ci; // Bit 7 is the carry into the top bit.
        return 10'((s & 511) | ((((lo >> 7) ^ (s >> 8)) & 1) << 9));
    endfunction : calc

    task automatic cmp_dp(input logic [9:0] e, input logic [9:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch datapath expected %h seen %h", e, g);
        end
    endtask : cmp_dp

    task automatic cmp_bus(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_bus

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // Handshakes are judged at the falling edge, where all levels have settled.
    task automatic axi_write(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
        bit da, dw, ta, tw, got;
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        da = 0;
        dw = 0;
        while (!(da && dw))
        begin
            @(negedge clk);
            ta = !da && s_axi_awready;
            tw = !dw && s_axi_wready;
            @(posedge clk);
            s_axi_awvalid <= s_axi_awvalid && !ta;
            s_axi_wvalid <= s_axi_wvalid && !tw;
            da = da || ta;
            dw = dw || tw;
        end
        // A late bready makes the response wait and hold.
        repeat (2) @(posedge clk);
        s_axi_bready <= 1'b1;
        got = 0;
        while (!got)
        begin
            @(negedge clk);
            got = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
        end
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        bit t;
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        t = 0;
        while (!t)
        begin
            @(negedge clk);
            t = s_axi_arready;
            @(posedge clk);
        end
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        t = 0;
        while (!t)
        begin
            @(negedge clk);
            t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
        end
        s_axi_rready <= 1'b0;
    endtask : axi_read

    ////////////////////////////////////////
    // Model runs at the falling edge; the queue holds P results in flight.
    always @(negedge clk)
    begin
        if (clear)
        begin
            armed = 1;
            q = '{10'h0, 10'h0};
            cmp_dp(10'h0, {overflow, carry_out, result});
        end
        else if (armed)
        begin
            q.push_back(calc(operand_a, operand_b, carry_in, m_ovr ? m_op : add_sel));
            cmp_dp(q.pop_front(), {overflow, carry_out, result});
        end
    end

    // A hang ends the run as a failure.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    initial
    begin
        logic [1:0]  r;
        logic [31:0] d;
        void'($urandom(10));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Default direction and representation leave their fields zero.
        axi_read(pasu_pkg::REG_CONFIG, d, r);
        cmp_bus("config", 32'(W + (P << pasu_pkg::CFG_LAT_LSB)), d);
        axi_read(8'h10, d, r);
        cmp_bus("unmapped resp", 32'(pasu_pkg::RESP_SLVERR), 32'(r));
        cmp_bus("unmapped data", 32'h0, d);
        axi_write(pasu_pkg::REG_RESULT, 32'hffffffff, r);
        cmp_bus("read-only resp", 32'(pasu_pkg::RESP_OKAY), 32'(r));
        axi_write(8'h10, 32'h0, r);
        cmp_bus("unmapped wr resp", 32'(pasu_pkg::RESP_SLVERR), 32'(r));
        // Port select, then forced add, then forced subtract.
        for (int m = 0; m < 3; m++)
        begin
            clear <= 1'b1;
            m_ovr = (m != 0);
            m_op = (m != 2);
            axi_write(pasu_pkg::REG_CTRL, {30'h0, m_op, m_ovr}, r);
            axi_read(pasu_pkg::REG_CTRL, d, r);
            cmp_bus("control", {30'h0, m_op, m_ovr}, d);
            axi_read(pasu_pkg::REG_FLAGS, d, r);
            cmp_bus("flags", 32'(m_ovr ? m_op : add_sel) << pasu_pkg::FLAG_OP_BIT, d);
            for (int i = 0; i < 80; i++)
            begin
                src_word <= (i < 4) ? EDGE_W[i] : 18'($urandom);
                clear <= (i == 40);
                @(posedge clk);
            end
        end
        print_verdict();
    end
endmodule : param_add_sub_unit_test

// >>> pasu_pipe.sv
// Result pipeline of configurable depth with asynchronous clear; at zero depth the clear is not used.
`timescale 1ns/1ps
module pasu_pipe
#(
    parameter int W   = 10,
    parameter int LAT = 0
)
(
    input  wire logic         clk,
    input  wire logic         clear,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    ////////////////////////////////////////////////////////////////////////////
    // Zero latency is a plain wire; otherwise a shift register of LAT words.
    ////////////////////////////////////////////////////////////////////////////

    generate
        if (LAT == 0)
        begin : g_comb
            // No flip-flop at all, so the clock is not used here.
            assign q = d;
        end
        else
        begin : g_regs
            // All pipeline words held in one packed state.
            typedef struct packed {
                logic [LAT-1:0][W-1:0] stage;
            } pasu_pipe_state_t;

            pasu_pipe_state_t st;       // Registered stages.
            pasu_pipe_state_t next_st;  // Next stage contents.

            // Each stage takes the one before it; stage 0 takes the input.
            always_comb
            begin
                next_st          = st;
                next_st.stage[0] = d;
                for (int i = 1; i < LAT; i++)
                begin
                    next_st.stage[i] = st.stage[i-1];
                end
            end

            // No power-up value on purpose: stages stay unknown until cleared.
            // The clear acts at once, without waiting for an edge.
            always_ff @(posedge clk or posedge clear)
            begin
                if (clear)
                begin
                    st <= '0;
                end
                else
                begin
                    st <= next_st;
                end
            end

            // The oldest stage drives the output.
            assign q = st.stage[LAT-1];
        end
    endgenerate

endmodule : pasu_pipe

// >>> pasu_pkg.sv
// Shared constants, register map and types for the add/subtract unit.
package pasu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Operation and representation settings.
    ////////////////////////////////////////////////////////////////////////////

    // Operation comes from the select port (also used for the unused setting).
    localparam int DIR_PORT   = 0;
    localparam int DIR_ADD    = 1;  // Fixed addition, select port ignored.
    localparam int DIR_SUB    = 2;  // Fixed subtraction, select port ignored.
    localparam int DIR_UNUSED = 3;  // Treated like the port setting.

    localparam int REP_SIGNED   = 0;  // Two's complement, the default.
    localparam int REP_UNSIGNED = 1;
    localparam int REP_UNUSED   = 2;

    // Default widths and latency of the datapath.
    localparam int DEF_WIDTH    = 8;
    localparam int DEF_PIPELINE = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus map.
    ////////////////////////////////////////////////////////////////////////////

    localparam int          ADDR_W     = 8;      // Byte address width.
    localparam int          DATA_W     = 32;     // Bus data width.
    localparam int          STRB_W     = 4;      // Byte enables.
    localparam logic [7:0]  REG_CTRL   = 8'h00;  // Software operation control.
    localparam logic [7:0]  REG_RESULT = 8'h04;  // Current result output.
    localparam logic [7:0]  REG_FLAGS  = 8'h08;  // Carry, overflow, operation.
    localparam logic [7:0]  REG_CONFIG = 8'h0c;  // Build-time settings.
    localparam logic [1:0]  ADDR_LSB   = 2'h0;   // Word alignment bits.

    localparam int CTRL_OVR_BIT  = 0;  // Software overrides the select port.
    localparam int CTRL_OP_BIT   = 1;  // Operation when overriding, 1 adds.
    localparam int FLAG_COUT_BIT = 0;
    localparam int FLAG_OVF_BIT  = 1;
    localparam int FLAG_OP_BIT   = 2;  // Operation in use now, 1 adds.
    localparam int CFG_WIDTH_LSB = 0;  // Eight-bit width field.
    localparam int CFG_LAT_LSB   = 8;  // Eight-bit latency field.
    localparam int CFG_DIR_LSB   = 16; // Two-bit direction field.
    localparam int CFG_REP_LSB   = 18; // Two-bit representation field.

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Which register an address selects.
    typedef enum logic [2:0] {SEL_CTRL, SEL_RESULT, SEL_FLAGS, SEL_CONFIG, SEL_NONE} pasu_sel_t;

endpackage : pasu_pkg

// >>> pasu_src.sv
// Source model of the upstream datapath feeding the unit.
`timescale 1ns/1ps
module pasu_src
(
    input  wire logic        clk,
    input  wire logic [17:0] word,
    output logic      [7:0]  operand_a = 8'h00,
    output logic      [7:0]  operand_b = 8'h00,
    output logic             carry_in  = 1'b0,
    output logic             add_sel   = 1'b1
);
    // A registered stage, so new operands land just after each edge.
    // The select stays a live signal; a fixed operation belongs in the unit's setting.
    always @(posedge clk)
    begin
        {add_sel, carry_in, operand_b, operand_a} <= word;
    end
endmodule : pasu_src

// >>> pasu_unit.sv
// Parameterised adder/subtractor with result pipeline and register bank.
`timescale 1ns/1ps
module pasu_unit
#(
    parameter int WIDTH          = pasu_pkg::DEF_WIDTH,
    parameter int DIRECTION      = pasu_pkg::DIR_PORT,
    parameter int REPRESENTATION = pasu_pkg::REP_SIGNED,
    parameter int PIPELINE       = pasu_pkg::DEF_PIPELINE
)
(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          clear,
    input  wire logic [WIDTH-1:0]              operand_a,
    input  wire logic [WIDTH-1:0]              operand_b,
    input  wire logic                          carry_in = 1'b0,
    input  wire logic                          add_sel  = 1'b1,
    output logic      [WIDTH-1:0]              result,
    output logic                               carry_out,
    output logic                               overflow,
    input  wire logic [pasu_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [pasu_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [pasu_pkg::STRB_W-1:0]   s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [pasu_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [pasu_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Local types and signals.
    ////////////////////////////////////////////////////////////////////////////

    // Width of the pipelined word: result, carry-out and overflow.
    localparam int PW = WIDTH + 2;

    // The whole bus-side state in one packed record.
    typedef struct packed {
        logic [pasu_pkg::ADDR_W-1:0] awaddr;  // Latched write address.
        logic                        aw_got;  // Write address held.
        logic [pasu_pkg::DATA_W-1:0] wdata;   // Latched write data.
        logic [pasu_pkg::STRB_W-1:0] wstrb;   // Latched byte enables.
        logic                        w_got;   // Write data held.
        logic                        bvalid;  // Write response pending.
        logic [1:0]                  bresp;   // Write response code.
        logic                        rvalid;  // Read data pending.
        logic [1:0]                  rresp;   // Read response code.
        logic [pasu_pkg::DATA_W-1:0] rdata;   // Read data word.
        logic                        ovr;     // Software drives the operation.
        logic                        op;      // Software operation, 1 adds.
    } pasu_state_t;

    pasu_state_t      st;        // Registered state.
    pasu_state_t      next_st;   // Next state from the combinational block.
    logic             op_add;    // Operation applied this cycle, 1 adds.
    logic [PW-1:0]    raw;       // Unregistered overflow, carry and result.
    logic [PW-1:0]    piped;     // Same word after the pipeline.
    logic [31:0]      cfg_word;  // Build settings as seen by software.

    ////////////////////////////////////////////////////////////////////////////
    // Functions.
    ////////////////////////////////////////////////////////////////////////////

    // Adds or subtracts; returns overflow, carry-out and result, high to low.
    // Subtraction is done as a plus inverted b plus carry-in, which is exactly
    // a minus b plus carry-in minus one, so one adder serves both operations.
    function automatic logic [PW-1:0] add_core
    (
        input logic [WIDTH-1:0] a,
        input logic [WIDTH-1:0] b,
        input logic             ci,
        input logic             add
    );
        logic [WIDTH-1:0] bb;
        logic [WIDTH:0]   sum;
        logic             c_msb;
        bb    = add ? b : ~b;
        sum   = {1'b0, a} + {1'b0, bb} + {{WIDTH{1'b0}}, ci};
        // The carry into the top bit is recovered from the top result bit and both top operand bits.
        c_msb = sum[WIDTH-1] ^ a[WIDTH-1] ^ bb[WIDTH-1];
        // Signed and unsigned share the same bits; only meaning differs.
        return {c_msb ^ sum[WIDTH], sum};
    endfunction : add_core

    // Maps a byte address to a register; low two bits are ignored.
    function automatic pasu_pkg::pasu_sel_t reg_sel
    (
        input logic [pasu_pkg::ADDR_W-1:0] addr
    );
        logic [7:0] word;
        word = {addr[pasu_pkg::ADDR_W-1:2], pasu_pkg::ADDR_LSB};
        case (word)
            pasu_pkg::REG_CTRL:   return pasu_pkg::SEL_CTRL;
            pasu_pkg::REG_RESULT: return pasu_pkg::SEL_RESULT;
            pasu_pkg::REG_FLAGS:  return pasu_pkg::SEL_FLAGS;
            pasu_pkg::REG_CONFIG: return pasu_pkg::SEL_CONFIG;
            default:              return pasu_pkg::SEL_NONE;
        endcase
    endfunction : reg_sel

    ////////////////////////////////////////////////////////////////////////////
    // Operation choice.
    ////////////////////////////////////////////////////////////////////////////

    // A fixed direction makes the select port and the override inert. With
    // the port setting, software may override; otherwise the port decides,
    // and an unconnected port defaults high, so the unit adds.
    always_comb
    begin
        case (DIRECTION)
            pasu_pkg::DIR_ADD:
            begin
                op_add = 1'b1;
            end
            pasu_pkg::DIR_SUB:
            begin
                op_add = 1'b0;
            end
            default:
            begin
                // Port setting and the unused setting both follow the port.
                op_add = st.ovr ? st.op : add_sel;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath and pipeline.
    ////////////////////////////////////////////////////////////////////////////

    // Both operands and the result share WIDTH; the flags ride along.
    assign raw = add_core(operand_a, operand_b, carry_in, op_add);

    // The flags travel in the same word as the result, so all three outputs
    // always describe the same operation, whatever the latency.
    pasu_pipe
    #(
        .W   (PW),
        .LAT (PIPELINE)
    )
    u_pipe
    (
        .clk   (clk),
        .clear (clear),
        .d     (raw),
        .q     (piped)
    );

    // Split the pipelined word back into its parts.
    assign result    = piped[WIDTH-1:0];
    assign carry_out = piped[WIDTH];
    assign overflow  = piped[WIDTH+1];

    ////////////////////////////////////////////////////////////////////////////
    // Register bus handshakes.
    ////////////////////////////////////////////////////////////////////////////

    // Address and data are taken independently and held until both are in.
    // Nothing new is taken while a response waits, which keeps one write
    // under way at a time.
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready  = !st.w_got && !st.bvalid;
    assign s_axi_arready = !st.rvalid;

    // Responses come straight from the state.
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp  = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp  = st.rresp;
    assign s_axi_rdata  = st.rdata;

    // Settings fixed at build time; representation only changes meaning.
    // Wider values than a field holds are cut to the field on purpose.
    always_comb
    begin
        cfg_word = '0;
        cfg_word[pasu_pkg::CFG_WIDTH_LSB +: 8] = 8'(WIDTH);
        cfg_word[pasu_pkg::CFG_LAT_LSB +: 8]   = 8'(PIPELINE);
        cfg_word[pasu_pkg::CFG_DIR_LSB +: 2]   = 2'(DIRECTION);
        cfg_word[pasu_pkg::CFG_REP_LSB +: 2]   = 2'(REPRESENTATION);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bus next-state logic.
    ////////////////////////////////////////////////////////////////////////////

    // Write path, read path and the control register all update here.
    always_comb
    begin
        next_st = st;

        // Capture the write address when offered and free.
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.awaddr = s_axi_awaddr;
            next_st.aw_got = 1'b1;
        end

        // Capture the write data when offered and free.
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
            next_st.w_got  = 1'b1;
        end

        // With both halves held, perform the write and raise the response.
        if (st.aw_got && st.w_got)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = pasu_pkg::RESP_OKAY;
            case (reg_sel(st.awaddr))
                pasu_pkg::SEL_CTRL:
                begin
                    // Both control bits live in byte lane zero.
                    if (st.wstrb[0])
                    begin
                        next_st.ovr = st.wdata[pasu_pkg::CTRL_OVR_BIT];
                        next_st.op  = st.wdata[pasu_pkg::CTRL_OP_BIT];
                    end
                end
                pasu_pkg::SEL_RESULT, pasu_pkg::SEL_FLAGS, pasu_pkg::SEL_CONFIG:
                begin
                    // Read-only registers accept and ignore a write.
                    next_st.bresp = pasu_pkg::RESP_OKAY;
                end
                default:
                begin
                    // Nothing lives here; the master is told so.
                    next_st.bresp = pasu_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (st.bvalid && s_axi_bready)
        begin
            // Response taken; the write side is free again.
            next_st.bvalid = 1'b0;
        end

        // Read: data are sampled at the address handshake and held.
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = pasu_pkg::RESP_OKAY;
            next_st.rdata  = '0;
            case (reg_sel(s_axi_araddr))
                pasu_pkg::SEL_CTRL:
                begin
                    next_st.rdata[pasu_pkg::CTRL_OVR_BIT] = st.ovr;
                    next_st.rdata[pasu_pkg::CTRL_OP_BIT]  = st.op;
                end
                pasu_pkg::SEL_RESULT:
                begin
                    // Results wider than the bus show their low word only.
                    next_st.rdata = 32'(result);
                end
                pasu_pkg::SEL_FLAGS:
                begin
                    next_st.rdata[pasu_pkg::FLAG_COUT_BIT] = carry_out;
                    next_st.rdata[pasu_pkg::FLAG_OVF_BIT]  = overflow;
                    next_st.rdata[pasu_pkg::FLAG_OP_BIT]   = op_add;
                end
                pasu_pkg::SEL_CONFIG:
                begin
                    next_st.rdata = cfg_word;
                end
                default:
                begin
                    next_st.rresp = pasu_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (st.rvalid && s_axi_rready)
        begin
            // Read data taken; accept the next address.
            next_st.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    ////////////////////////////////////////////////////////////////////////////

    // The bus side resets with the system; the datapath pipeline does not,
    // it answers only to its own clear input.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : pasu_unit

// >>> pasu_unit_props.sv
// Concurrent checks on the ports of the add/subtract unit.
`timescale 1ns/1ps
module pasu_props
#(
    parameter int WIDTH    = 8,
    parameter int PIPELINE = 2
)
(
    input wire logic             clk,
    input wire logic             sys_rst,
    input wire logic             clear,
    input wire logic [WIDTH-1:0] operand_a,
    input wire logic [WIDTH-1:0] operand_b,
    input wire logic             carry_in,
    input wire logic             add_sel,
    input wire logic [WIDTH-1:0] result,
    input wire logic             carry_out,
    input wire logic             overflow,
    input wire logic [7:0]       s_axi_awaddr,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic [31:0]      s_axi_wdata,
    input wire logic [3:0]       s_axi_wstrb,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid
);
    ////////////////////////////////////////
    logic [1:0] ctrl_copy; // Mirror of the override and operation bits.
    logic [1:0] fill;      // Edges since clear; saturates, so PIPELINE above 3 is not covered.
    logic       eff_add;   // Operation the unit should be using.

    assign eff_add = ctrl_copy[0] ? ctrl_copy[1] : add_sel;

    // The mirror leads the unit by one edge; harmless, as writes happen under clear.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_copy <= 2'h0;
            fill      <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                && s_axi_awaddr[7:2] == 6'h00 && s_axi_wstrb[0])
            begin
                ctrl_copy <= s_axi_wdata[1:0];
            end
            fill <= clear ? 2'h0 : ((fill == 2'h3) ? fill : fill + 2'h1);
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sum_path_a: assert property (
        (!clear && fill >= PIPELINE && $past(eff_add, PIPELINE)) |-> {carry_out, result} ==
        {1'b0, $past(operand_a, PIPELINE)} + {1'b0, $past(operand_b, PIPELINE)}
        + $past(carry_in, PIPELINE)) else $error("sum path result wrong");
    diff_path_a: assert property (
        (!clear && fill >= PIPELINE && !$past(eff_add, PIPELINE)) |-> {carry_out, result} ==
        {1'b0, $past(operand_a, PIPELINE)} + {1'b0, ~$past(operand_b, PIPELINE)}
        + $past(carry_in, PIPELINE)) else $error("difference path result wrong");
    ovf_flag_a: assert property (
        (!clear && fill >= PIPELINE) |-> overflow == (carry_out ^ result[WIDTH-1]
        ^ $past(operand_a[WIDTH-1], PIPELINE) ^ $past(operand_b[WIDTH-1], PIPELINE)
        ^ !$past(eff_add, PIPELINE))) else $error("overflow flag wrong");
    clear_zero_a: assert property (
        clear |-> result == '0 && !carry_out && !overflow) else $error("clear not zero");
    // Needs a depth of two: both stages must drain their zeros.
    clear_tail_a: assert property (
        $fell(clear) |-> (result == '0 && !carry_out)[*2]) else $error("clear tail lost");
    resp_wait_a: assert property (
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    read_wait_a: assert property (
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("read data missing");
    resp_hold_a: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_block_a: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule : pasu_props

bind pasu_unit pasu_props #(.WIDTH(WIDTH), .PIPELINE(PIPELINE)) u_props (.*);
